// file: design/cdb_regs.svh
// Purpose: Register map, field places and reset values of the CDB decoder
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef CDB_REGS_SVH
`define CDB_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CDB_OFS_CTRL     8'h00
`define CDB_OFS_STATUS   8'h04
`define CDB_OFS_IRQ_EN   8'h08
`define CDB_OFS_IRQ_CLR  8'h0C
`define CDB_OFS_INFO     8'h10
`define CDB_OFS_LBA      8'h14
`define CDB_OFS_LEN      8'h18

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define CDB_CTRL_EN_BIT    0
`define CDB_CTRL_LINK_BIT  1
`define CDB_CTRL_RESET     2'h1
`define CDB_ST_DONE_BIT    0
`define CDB_ST_ERR_BIT     1
`define CDB_ST_W           2

// ----------------------------------------------------------------------
// Command descriptor block layout
// ----------------------------------------------------------------------
`define CDB_LEN_SIX        4'h6
`define CDB_LEN_TEN        4'hA
`define CDB_LEN_TWELVE     4'hC
`define CDB_LEN_NONE       4'h0
`define CDB_MAX_BYTES      12
`define CDB_GRP_SIX        3'h0
`define CDB_GRP_TEN_A      3'h1
`define CDB_GRP_TEN_B      3'h2
`define CDB_GRP_TWELVE     3'h5
`define CDB_TEN_RSVD_BYTE  6
`define CDB_TWL_RSVD_BYTE  10

`endif

// file: design/cdb_pkg.sv
// Purpose: Types shared by the CDB decoder and its bench
// Assumes: Constants live in cdb_regs.svh
// Notes:   No imports anywhere; use cdb_pkg::name
package cdb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_COLLECT = 2'b01,
    ST_CHECK   = 2'b10
  } state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [2:0]  group;
    logic [4:0]  cmd_code;
    logic [2:0]  lun;
    logic [31:0] lba;
    logic [31:0] xfer_len;
    logic [7:0]  control;
    logic        check_cond;
    logic        illegal_req;
    logic        medium_ok;
    logic        link;
    logic        flag;
  } cdb_result_t;

endpackage

// file: design/scsi_cdb_decoder.sv
// Purpose: Collect a command descriptor block byte by byte and decode it
// Assumes: Bytes arrive synchronous to clock on a valid/ready handshake
// Notes:   Registers on APB, zero wait states, one level interrupt
//
// Operation
// RULE_01 - Byte zero of every received block is taken as the operation code.
// RULE_02 - Every mandatory operation code is accepted by the supported table.
// RULE_03 - Initiator drives reserved bits, fields and bytes to zero.
// RULE_04 - Non-zero reserved content or reserved code gives check, illegal.
// RULE_05 - Initiator never sends reserved codes; vendor codes are vendor's.
// RULE_06 - Supported optional commands behave exactly as standard defines.
// RULE_07 - Block starts with operation code and ends with control byte.
// RULE_08 - Invalid parameter ends the command and leaves the medium alone.
// RULE_09 - Some commands are followed by a parameter list in data out.
// RULE_10 - Group code is upper three bits, command code lower five.
// RULE_11 - Group 0 six, 1 and 2 ten, 5 twelve bytes; others not.
// RULE_12 - Six-byte: unit in byte 1 top, address to byte 3, length 4.
// RULE_13 - Ten-byte: address bytes 2-5, byte 6 reserved, length 7-8.
// RULE_14 - Twelve-byte: address 2-5, length 6-9, byte 10 reserved.
// RULE_15 - After identify, the unit number field in the block is ignored.
// RULE_16 - Address is 21 bits in six-byte, 32 bits in longer blocks.
// RULE_17 - Link zero with flag one gives check condition, illegal request.
// RULE_18 - First byte fixes remaining count; checks start after control byte.
// RULE_19 - Reserved and vendor groups are invalid: check, illegal request.
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "cdb_regs.svh"

module scsi_cdb_decoder #(
  parameter logic [255:0] SUPPORTED_OPS = {
    64'h0000_0000_0000_0000, 32'hFFFF_FFFF, 64'h0000_0000_0000_0000,
    96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF}
) (
  input  wire  logic                 clock,
  input  wire  logic                 rst,
  input  wire  cdb_pkg::apb_req_t    apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire  logic [7:0]           cdb_byte,
  input  wire  logic                 cdb_valid,
  output logic                       cdb_ready,
  input  wire  logic                 lun_identified,
  input  wire  logic [2:0]           identify_lun,
  output cdb_pkg::cdb_result_t       result,
  output logic                       result_valid,
  output logic                       irq
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [3:0] group_len(input logic [2:0] grp);
    unique case (grp)
      `CDB_GRP_SIX:    group_len = `CDB_LEN_SIX;     // [RULE_11]
      `CDB_GRP_TEN_A,
      `CDB_GRP_TEN_B:  group_len = `CDB_LEN_TEN;     // [RULE_11]
      `CDB_GRP_TWELVE: group_len = `CDB_LEN_TWELVE;  // [RULE_11]
      default:         group_len = `CDB_LEN_NONE;    // [RULE_19]
    endcase
  endfunction

  cdb_pkg::state_t   state_reg;
  cdb_pkg::state_t   state_next;
  logic [7:0]        buf_reg [`CDB_MAX_BYTES];
  logic [3:0]        count_reg;
  logic [3:0]        len_reg;
  logic [1:0]        ctrl_reg;
  logic [`CDB_ST_W-1:0] status_reg;
  logic [`CDB_ST_W-1:0] irq_en_reg;
  logic              take;
  logic              last_byte;
  logic              apb_wr;
  logic              apb_rd;
  cdb_pkg::cdb_result_t dec;

  assign take      = cdb_valid && cdb_ready;
  assign last_byte = take && (count_reg + 4'h1 == len_reg);
  assign apb_wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign apb_rd    = apb_req.psel && !apb_req.pwrite;

  // --------------------------------------------------------------------
  // Collection state machine
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      cdb_pkg::ST_IDLE: begin
        if (take) begin
          // Unknown groups have no length, so judge them on byte zero
          if (group_len(cdb_byte[7:5]) == `CDB_LEN_NONE) begin
            state_next = cdb_pkg::ST_CHECK;         // [RULE_19]
          end else begin
            state_next = cdb_pkg::ST_COLLECT;       // [RULE_18]
          end
        end
      end
      cdb_pkg::ST_COLLECT: begin
        if (last_byte) begin
          state_next = cdb_pkg::ST_CHECK;           // [RULE_07] [RULE_18]
        end
      end
      cdb_pkg::ST_CHECK: state_next = cdb_pkg::ST_IDLE;
      default:           state_next = cdb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= cdb_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Ready is dropped for the check cycle so no byte of the next block mixes
  always_ff @(posedge clock) begin
    if (rst) begin
      cdb_ready <= 1'b0;
    end else begin
      cdb_ready <= ctrl_reg[`CDB_CTRL_EN_BIT] &&
                   (state_next != cdb_pkg::ST_CHECK);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= 4'h0;
      len_reg   <= `CDB_LEN_NONE;
    end else if (take && state_reg == cdb_pkg::ST_IDLE) begin
      count_reg <= 4'h1;
      len_reg   <= group_len(cdb_byte[7:5]);        // [RULE_18]
    end else if (take) begin
      count_reg <= count_reg + 4'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `CDB_MAX_BYTES; gi++) begin : g_byte
      always_ff @(posedge clock) begin
        if (rst) begin
          buf_reg[gi] <= 8'h00;
        end else if (take && state_reg == cdb_pkg::ST_IDLE) begin
          // Byte zero is always the operation code
          buf_reg[gi] <= (gi == 0) ? cdb_byte : 8'h00;  // [RULE_01]
        end else if (take && count_reg == 4'(gi)) begin
          buf_reg[gi] <= cdb_byte;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Field decode and checks, valid only in the check cycle
  // --------------------------------------------------------------------
  always_comb begin
    logic [7:0] ctl;
    logic       bad;
    ctl = 8'h00;
    bad = 1'b0;
    dec = '0;
    dec.opcode   = buf_reg[0];                      // [RULE_01]
    dec.group    = buf_reg[0][7:5];                 // [RULE_10]
    dec.cmd_code = buf_reg[0][4:0];                 // [RULE_10]
    // Unit number field only counts when no identify selected a unit
    dec.lun = lun_identified ? identify_lun : buf_reg[1][7:5]; // [RULE_15]
    unique case (len_reg)
      `CDB_LEN_SIX: begin
        dec.lba      = {11'h000, buf_reg[1][4:0], buf_reg[2],
                        buf_reg[3]};                 // [RULE_12] [RULE_16]
        dec.xfer_len = {24'h00_0000, buf_reg[4]};   // [RULE_12]
        ctl          = buf_reg[5];
      end
      `CDB_LEN_TEN: begin
        dec.lba      = {buf_reg[2], buf_reg[3], buf_reg[4],
                        buf_reg[5]};                 // [RULE_13] [RULE_16]
        dec.xfer_len = {16'h0000, buf_reg[7], buf_reg[8]}; // [RULE_13]
        ctl          = buf_reg[9];
        bad = bad || (buf_reg[`CDB_TEN_RSVD_BYTE] != 8'h00); // [RULE_04]
      end
      `CDB_LEN_TWELVE: begin
        dec.lba      = {buf_reg[2], buf_reg[3], buf_reg[4],
                        buf_reg[5]};                 // [RULE_14] [RULE_16]
        dec.xfer_len = {buf_reg[6], buf_reg[7], buf_reg[8],
                        buf_reg[9]};                 // [RULE_14] [RULE_09]
        ctl          = buf_reg[11];
        bad = bad || (buf_reg[`CDB_TWL_RSVD_BYTE] != 8'h00); // [RULE_04]
      end
      default: begin
        bad = 1'b1;                                  // [RULE_19] [RULE_05]
      end
    endcase
    dec.control = ctl;                               // [RULE_07]
    dec.link    = ctl[0];
    dec.flag    = ctl[1];
    bad = bad || (ctl[5:2] != 4'h0);                 // [RULE_04]
    bad = bad || (!ctl[0] && ctl[1]);                // [RULE_17]
    // Linking is optional; without it either bit is refused
    bad = bad || (!ctrl_reg[`CDB_CTRL_LINK_BIT] && (ctl[1:0] != 2'b00));
    // Unsupported codes are refused rather than half executed
    bad = bad || !SUPPORTED_OPS[buf_reg[0]];         // [RULE_02] [RULE_06]
    dec.check_cond  = bad;                           // [RULE_04]
    dec.illegal_req = bad;                           // [RULE_04]
    dec.medium_ok   = !bad;                          // [RULE_08]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      // Result holds until the next block is judged, so software may read late
      result_valid <= (state_reg == cdb_pkg::ST_CHECK);
      if (state_reg == cdb_pkg::ST_CHECK) begin
        result <= dec;                               // [RULE_08]
      end
    end
  end

  // --------------------------------------------------------------------
  // Registers and interrupt
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_reg   <= `CDB_CTRL_RESET;
      irq_en_reg <= '0;
    end else if (apb_wr) begin
      if (apb_req.paddr == `CDB_OFS_CTRL) begin
        ctrl_reg <= apb_req.pwdata[1:0];
      end
      if (apb_req.paddr == `CDB_OFS_IRQ_EN) begin
        irq_en_reg <= apb_req.pwdata[`CDB_ST_W-1:0];
      end
    end
  end

  // Sticky events: a new event wins over a clear in the same cycle
  logic [`CDB_ST_W-1:0] st_ev;
  logic [`CDB_ST_W-1:0] st_clr;

  always_comb begin
    st_ev                   = '0;
    st_ev[`CDB_ST_DONE_BIT] = (state_reg == cdb_pkg::ST_CHECK);
    st_ev[`CDB_ST_ERR_BIT]  = (state_reg == cdb_pkg::ST_CHECK) &&
                              dec.check_cond;
  end

  // Only a write to the clear register may drop a status bit
  assign st_clr = (apb_wr && apb_req.paddr == `CDB_OFS_IRQ_CLR) ?
                  apb_req.pwdata[`CDB_ST_W-1:0] : '0;

  always_ff @(posedge clock) begin
    if (rst) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_ev;
    end
  end

  // Registered so the pin is glitch free; it trails status by a cycle,
  // so a clear reaches the pin two cycles after the write
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & irq_en_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // Zero wait states: data is latched in setup and stands in access;
      // a slower source would need pready held low instead
      pready  <= apb_req.psel && !apb_req.penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_req.psel && !apb_req.penable) begin
        unique case (apb_req.paddr)
          `CDB_OFS_CTRL:    prdata <= {30'h0, ctrl_reg};
          `CDB_OFS_STATUS:  prdata <= {30'h0, status_reg};
          `CDB_OFS_IRQ_EN:  prdata <= {30'h0, irq_en_reg};
          `CDB_OFS_IRQ_CLR: prdata <= 32'h0000_0000;
          `CDB_OFS_INFO:    prdata <= {result.opcode, result.control,
                                       5'h00, result.lun,
                                       3'h0, result.flag, result.link,
                                       result.medium_ok,
                                       result.illegal_req,
                                       result.check_cond};
          `CDB_OFS_LBA:     prdata <= result.lba;
          `CDB_OFS_LEN:     prdata <= result.xfer_len;
          default:          pslverr <= 1'b1;
        endcase
        if (apb_rd == 1'b0) begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule

// file: tb/cdb_chk.sv
// Purpose: Concurrent checks on the CDB decoder ports
// Assumes: Bound to every scsi_cdb_decoder instance
// Notes:   Byte count of the block in flight is kept in helper logic
`timescale 1ns/1ps
module cdb_chk (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire cdb_pkg::apb_req_t    apb_req,
  input wire logic                 pready,
  input wire logic [7:0]           cdb_byte,
  input wire logic                 cdb_valid,
  input wire logic                 cdb_ready,
  input wire logic                 lun_identified,
  input wire logic [2:0]           identify_lun,
  input wire cdb_pkg::cdb_result_t result,
  input wire logic                 result_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ---
  // Byte tracking
  // ---
  logic [3:0] cnt;
  logic [3:0] c;
  logic [7:0] op;
  logic [2:0] g;
  logic       rsv;
  logic       take;
  logic       last;
  logic       rb;
  function automatic logic [3:0] lenf(input logic [2:0] x);
    case (x)
      3'h0: return 4'h6;
      3'h1, 3'h2: return 4'hA;
      3'h5: return 4'hC;
      default: return 4'h1;
    endcase
  endfunction
  assign take = cdb_valid && cdb_ready;
  // A new opcode may be taken in the very cycle the result shows
  assign c    = result_valid ? 4'h0 : cnt;
  assign g    = (c == 4'h0) ? cdb_byte[7:5] : op[7:5];
  assign last = take && (c + 4'h1 == lenf(g));
  assign rb   = (c == 4'h6 && lenf(g) == 4'hA) ||
                (c == 4'hA && lenf(g) == 4'hC);
  always_ff @(posedge clock) begin
    if (rst) begin
      cnt <= 4'h0;
      rsv <= 1'b0;
    end else if (take) begin
      cnt <= c + 4'h1;
      rsv <= (c != 4'h0) && (rsv || (rb && cdb_byte != 8'h00));
    end else if (result_valid) begin
      cnt <= 4'h0;
      rsv <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (take && c == 4'h0) begin
      op <= cdb_byte;
    end
  end
  // ---
  // Properties
  // ---
  sequence answer_s;
    !result_valid ##1 result_valid;
  endsequence
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  answer_two_a: assert property (last |=> answer_s)
    else $error("result not two cycles after last byte");
  gap_ready_a: assert property (last |=> !cdb_ready)
    else $error("byte accepted in check cycle");
  block_len_a: assert property (
    result_valid |-> cnt == lenf(result.group))
    else $error("byte count does not match group");
  opcode_a: assert property (result_valid |-> result.opcode == op)
    else $error("opcode is not the first byte");
  split_a: assert property (
    result_valid |-> {result.group, result.cmd_code} == result.opcode)
    else $error("group or command code split wrong");
  bad_group_a: assert property (
    result_valid && lenf(result.group) == 4'h1
    |-> result.check_cond && result.illegal_req)
    else $error("reserved or vendor group accepted");
  flag_link_a: assert property (
    result_valid && result.control[1:0] == 2'h2
    |-> result.check_cond && result.illegal_req)
    else $error("flag without link accepted");
  rsv_byte_a: assert property (
    result_valid && rsv |-> result.check_cond && result.illegal_req)
    else $error("non-zero reserved byte accepted");
  medium_a: assert property (
    result_valid && result.check_cond |-> !result.medium_ok)
    else $error("medium change allowed on bad block");
  short_lba_a: assert property (
    result_valid && result.group == 3'h0 |-> result.lba[31:21] == 11'h0)
    else $error("six-byte address wider than 21 bits");
  unit_a: assert property (
    result_valid && lun_identified |-> result.lun == identify_lun)
    else $error("unit field used after identify");
  apb_ready_a: assert property (setup_s |=> pready)
    else $error("no ready in access cycle");
endmodule

bind scsi_cdb_decoder cdb_chk u_chk (
  .clock(clock), .rst(rst), .apb_req(apb_req), .pready(pready),
  .cdb_byte(cdb_byte), .cdb_valid(cdb_valid), .cdb_ready(cdb_ready),
  .lun_identified(lun_identified), .identify_lun(identify_lun),
  .result(result), .result_valid(result_valid)
);

// file: tb/cdb_initiator.sv
// Purpose: Initiator model offering command bytes on valid/ready
// Assumes: A byte is taken at the edge where valid and ready are high
// Notes:   Idle data line shows the inverted byte, but a slow block's first idle shows the previous block's last byte again
`timescale 1ns/1ps
module cdb_initiator (
  input  wire logic       clock,
  input  wire logic       cdb_ready,
  output logic      [7:0] cdb_byte,
  output logic            cdb_valid
);
  // ---
  // Block sender
  // ---
  initial begin
    cdb_byte  = 8'h00;
    cdb_valid = 1'b0;
  end
  // Slow mode idles one cycle before each byte
  task automatic send(input logic [95:0] blk, input int n, input bit slow);
    for (int i = 0; i < n; i++) begin
      if (slow) begin
        cdb_valid <= 1'b0;
        cdb_byte  <= ~cdb_byte;
        @(posedge clock);
      end
      cdb_valid <= 1'b1;
      cdb_byte  <= blk[95-8*i -: 8];
      do @(posedge clock); while (cdb_ready !== 1'b1);
    end
    cdb_valid <= 1'b0;
    cdb_byte  <= ~cdb_byte;
  endtask
endmodule

// file: tb/testbench.sv
// Purpose: Random and corner command blocks plus register checks
// Assumes: Zero-wait APB, linking disabled after reset
// Notes:   Expected fields are rebuilt from the bytes sent
`timescale 1ns/1ps
`include "cdb_regs.svh"
module testbench;
  logic                 clock, rst, lun_identified, e;
  logic [2:0]           identify_lun;
  cdb_pkg::apb_req_t    apb_req;
  cdb_pkg::cdb_result_t result;
  logic [31:0]          prdata, q;
  logic                 pready, pslverr, cdb_ready, cdb_valid;
  logic                 result_valid, irq;
  logic [7:0]           cdb_byte;
  logic [7:0]           b [0:11];
  logic [95:0]          blk;
  integer               seed = 32'h28af;
  int                   n_fail, checks_done, cyc, k, n;
  bit                   lk;
  logic [2:0]           xl;

  scsi_cdb_decoder DUT (.clock(clock), .rst(rst), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cdb_byte(cdb_byte), .cdb_valid(cdb_valid), .cdb_ready(cdb_ready),
    .lun_identified(lun_identified), .identify_lun(identify_lun),
    .result(result), .result_valid(result_valid), .irq(irq));
  cdb_initiator ini (.clock(clock), .cdb_ready(cdb_ready),
    .cdb_byte(cdb_byte), .cdb_valid(cdb_valid));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  // ---
  // Expectations and drivers
  // ---
  function automatic int nbytes(input logic [2:0] g);
    case (g)
      3'h0: return 6;
      3'h1, 3'h2: return 10;
      3'h5: return 12;
      default: return 1;
    endcase
  endfunction
  function automatic logic [31:0] exp_lba(input int m);
    if (m == 6) return {11'h0, b[1][4:0], b[2], b[3]};
    return {b[2], b[3], b[4], b[5]};
  endfunction
  function automatic logic [31:0] exp_len(input int m);
    if (m == 6) return {24'h0, b[4]};
    if (m == 10) return {16'h0, b[7], b[8]};
    return {b[6], b[7], b[8], b[9]};
  endfunction
  function automatic logic exp_err(input int m);
    logic [7:0] c;
    c = b[m-1];
    return m == 1 || c[5:2] != 4'h0 || (!c[0] && c[1]) ||
      (!lk && c[1:0] != 2'b00) ||
      (m == 10 && b[6] != 8'h00) || (m == 12 && b[10] != 8'h00);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, 1'b0);
  endtask
  // Clean blocks keep reserved bytes and control bits 5:0 at zero
  task automatic mk(input logic [7:0] op, input bit clean);
    // Clean blocks never carry a reserved group: those go to vendor ones
    if (clean && (op[7:5] == 3'h3 || op[7:5] == 3'h4))
      op[7:6] = 2'b11;
    n = nbytes(op[7:5]);
    foreach (b[i]) b[i] = 8'($random(seed));
    b[0] = op;
    if (n == 10) b[6] = 8'h00;
    if (n == 12) b[10] = 8'h00;
    if (clean && n > 1) b[n-1] = b[n-1] & 8'hc0;
  endtask
  task automatic go(input bit slow);
    int i;
    @(posedge clock);
    lun_identified <= 1'($random(seed));
    identify_lun   <= 3'($random(seed));
    for (i = 0; i < 12; i++) blk[95-8*i -: 8] = b[i];
    ini.send(blk, n, slow);
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (result_valid !== 1'b1 && i < 20);
    chk(result_valid, 1'b1);
    chk(result.opcode, b[0]);
    chk({result.group, result.cmd_code}, b[0]);
    chk(result.check_cond, exp_err(n));
    chk(result.illegal_req, exp_err(n));
    chk(result.medium_ok, !exp_err(n));
    xl = lun_identified ? identify_lun : b[1][7:5];
    if (n > 1) begin
      chk(result.lun, xl);
      chk({result.flag, result.link}, b[n-1][1:0]);
      chk(result.lba, exp_lba(n));
      chk(result.xfer_len, exp_len(n));
      chk(result.control, b[n-1]);
    end
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ---
  // Main sequence
  // ---
  initial begin
    rst = 1'b1;
    apb_req = '0;
    lun_identified = 1'b0;
    identify_lun = 3'h0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rchk(`CDB_OFS_CTRL, 32'h0000_0001);
    rchk(`CDB_OFS_STATUS, 32'h0000_0000);
    rchk(`CDB_OFS_IRQ_CLR, 32'h0000_0000);
    apb(1'b0, 8'h1c, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, `CDB_OFS_IRQ_EN, 32'h0000_0003);
    for (k = 0; k < 48; k++) begin
      if (k < 8) mk({k[2:0], 5'($random(seed))}, (k != 3 && k != 4));
      else mk(8'($random(seed)), k % 4 != 3);
      if (k == 8) begin
        mk(8'h28, 1'b1);
        b[6] = 8'h5a;
      end
      if (k == 9) begin
        mk(8'h08, 1'b1);
        b[5] = 8'h02;
      end
      if (k == 10) begin
        mk(8'h08, 1'b1);
        b[1][4:0] = 5'h1f;
        b[2] = 8'hff;
        b[3] = 8'hff;
      end
      if (k == 11) begin
        mk(8'ha8, 1'b1);
        b[10] = 8'h01;
      end
      go(k[0]);
    end
    rchk(`CDB_OFS_STATUS, 32'h0000_0003);
    chk(irq, 1'b1);
    apb(1'b1, `CDB_OFS_IRQ_CLR, 32'h0000_0003);
    rchk(`CDB_OFS_STATUS, 32'h0000_0000);
    chk(irq, 1'b0);
    apb(1'b1, `CDB_OFS_IRQ_EN, 32'h0000_0000);
    mk(8'h08, 1'b1);
    go(1'b0);
    rchk(`CDB_OFS_STATUS, 32'h0000_0001);
    chk(irq, 1'b0);
    rchk(`CDB_OFS_LBA, exp_lba(n));
    rchk(`CDB_OFS_LEN, exp_len(n));
    rchk(`CDB_OFS_INFO, {b[0], b[5], 5'h00, xl, 8'h04});
    // Linking on: link alone, flag alone, then both
    apb(1'b1, `CDB_OFS_CTRL, 32'h0000_0003);
    lk = 1'b1;
    for (k = 0; k < 3; k++) begin
      mk(8'h28, 1'b1);
      b[9] = 8'(k + 1);
      go(1'b0);
    end
    // Decoder off: no byte may be taken
    apb(1'b1, `CDB_OFS_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clock);
    chk(cdb_ready, 1'b0);
    wrap_up();
  end
endmodule
